/* src/serial_frame_format.sv */
// frame-format engine: receive and transmit framers on their own bit clocks
`timescale 1ns/10ps
`default_nettype none
`include "serial_frame_format_regs.svh"
module serial_frame_format
  import serial_frame_format_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire frame_cfg_t rx_cfg,
  input wire frame_cfg_t tx_cfg,
  input wire logic rx_bit_clock,
  input wire logic rx_frame_sync,
  input wire logic rx_serial_in,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  output logic tx_serial_out,
  output logic tx_serial_oe_n,
  output logic [31:0] rx_data_holding,
  output logic rx_data_valid,
  input wire logic [31:0] tx_data_holding,
  input wire logic tx_data_write,
  output logic tx_ready,
  output logic rx_busy,
  output logic tx_busy,
  output logic rx_overrun,
  input wire logic rx_overrun_clr,
  output logic tx_underrun,
  input wire logic tx_underrun_clr
);

  // element length minus one for a length code
  function automatic logic [4:0] elem_len_m1(input logic [2:0] code);
    logic [4:0] len;
    len = `ELEM_LEN_8;
    case (code)
      `ELEM_CODE_8: len = `ELEM_LEN_8;
      `ELEM_CODE_12: len = `ELEM_LEN_12;
      `ELEM_CODE_16: len = `ELEM_LEN_16;
      `ELEM_CODE_20: len = `ELEM_LEN_20;
      `ELEM_CODE_24: len = `ELEM_LEN_24;
      `ELEM_CODE_32: len = `ELEM_LEN_32;
      // reserved codes fall back to the shortest element
      default: len = `ELEM_LEN_8;
    endcase
    return len;
  endfunction

  // phase two is only ever entered in dual mode, so its fields stay unread otherwise
  function automatic logic [4:0] phase_len(input frame_cfg_t c, input logic phase);
    return phase ? elem_len_m1(c.p2_bits) : elem_len_m1(c.p1_bits);
  endfunction

  function automatic logic [6:0] phase_count(input frame_cfg_t c, input logic phase);
    return phase ? c.p2_count : c.p1_count;
  endfunction

  function automatic logic more_phase(input frame_cfg_t c, input logic phase);
    return !phase && (c.dual == `PHASE_DUAL);
  endfunction

  // reserved delay code behaves as the two-bit delay
  function automatic logic [1:0] clamp_delay(input logic [1:0] d);
    return (d == `DLY_RSVD) ? `DLY_TWO : d;
  endfunction

  function automatic logic [31:0] left_align(input logic [31:0] w, input logic [4:0] len);
    return w << (`SHIFT_TOP - len);
  endfunction

  // one received bit; closes elements, phases and the frame
  function automatic rx_link_t rx_step(input rx_link_t cur, input logic din,
                                       input logic word_busy);
    rx_link_t s;
    s = cur;
    s.state = LINK_SHIFT;
    s.shift = {cur.shift[30:0], din};
    if (cur.bits_left == 5'h00) begin
      s.word = {cur.shift[30:0], din};
      s.send = 1'b1;
      s.ovr_tgl = cur.ovr_tgl ^ word_busy;
      s.shift = `WORD_RESET;
      if (cur.elems_left != 7'h00) begin
        s.elems_left = cur.elems_left - 7'h01;
        s.bits_left = phase_len(cur.cfg, cur.phase);
      end else if (more_phase(cur.cfg, cur.phase)) begin
        s.phase = 1'b1;
        s.elems_left = phase_count(cur.cfg, 1'b1);
        s.bits_left = phase_len(cur.cfg, 1'b1);
      end else begin
        s.state = LINK_IDLE;
        s.phase = 1'b0;
      end
    end else begin
      s.bits_left = cur.bits_left - 5'h01;
    end
    s.busy = (s.state != LINK_IDLE);
    return s;
  endfunction

  // one transmit bit time; loads the next element at each boundary
  function automatic tx_link_t tx_step(input tx_link_t cur, input frame_cfg_t live);
    tx_link_t s;
    s = cur;
    if (cur.bits_left == 5'h00) begin
      if (cur.elems_left != 7'h00) begin
        s.elems_left = cur.elems_left - 7'h01;
        s.bits_left = phase_len(cur.cfg, cur.phase);
      end else if (more_phase(cur.cfg, cur.phase)) begin
        s.phase = 1'b1;
        s.elems_left = phase_count(cur.cfg, 1'b1);
        s.bits_left = phase_len(cur.cfg, 1'b1);
      end else begin
        s.state = LINK_IDLE;
        s.phase = 1'b0;
      end
      if (s.state == LINK_IDLE) begin
        s.shift = left_align(cur.next_word, phase_len(live, 1'b0));
      end else begin
        s.shift = left_align(cur.next_word, s.bits_left);
        // an element with no new word repeats the last one
        s.unf_tgl = cur.unf_tgl ^ ~cur.fresh;
        s.fresh = 1'b0;
      end
    end else begin
      s.shift = {cur.shift[30:0], 1'b0};
      s.bits_left = cur.bits_left - 5'h01;
    end
    s.busy = (s.state != LINK_IDLE);
    return s;
  endfunction

  frame_cfg_t rx_cfg_link;
  frame_cfg_t tx_cfg_link;
  logic rx_cfg_busy;
  logic tx_cfg_busy;
  logic rx_word_busy;
  logic tx_word_valid;
  logic [31:0] tx_word_link;
  logic tx_word_busy;
  logic rx_busy_s;
  logic tx_busy_s;
  logic ovr_s;
  logic unf_s;

  rx_link_t rx_ff;
  rx_link_t nxt_rx;
  tx_link_t tx_ff;
  tx_link_t nxt_tx;
  sys_state_t sys_ff;
  sys_state_t nxt_sys;

  // settings are resent whenever the crossing is idle, so the link side tracks them
  word_xfer #(.WIDTH($bits(frame_cfg_t))) u_rx_cfg_xfer (
    .rst(sys_rst),
    .src_clk(clk),
    .src_send(1'b1),
    .src_data(rx_cfg),
    .src_busy(rx_cfg_busy),
    .dst_clk(rx_bit_clock),
    .dst_data(rx_cfg_link),
    .dst_valid()
  );

  word_xfer #(.WIDTH($bits(frame_cfg_t))) u_tx_cfg_xfer (
    .rst(sys_rst),
    .src_clk(clk),
    .src_send(1'b1),
    .src_data(tx_cfg),
    .src_busy(tx_cfg_busy),
    .dst_clk(tx_bit_clock),
    .dst_data(tx_cfg_link),
    .dst_valid()
  );

  word_xfer #(.WIDTH(32)) u_rx_word_xfer (
    .rst(sys_rst),
    .src_clk(rx_bit_clock),
    .src_send(rx_ff.send),
    .src_data(rx_ff.word),
    .src_busy(rx_word_busy),
    .dst_clk(clk),
    .dst_data(rx_data_holding),
    .dst_valid(rx_data_valid)
  );

  word_xfer #(.WIDTH(32)) u_tx_word_xfer (
    .rst(sys_rst),
    .src_clk(clk),
    .src_send(tx_data_write),
    .src_data(tx_data_holding),
    .src_busy(tx_word_busy),
    .dst_clk(tx_bit_clock),
    .dst_data(tx_word_link),
    .dst_valid(tx_word_valid)
  );

  bit_sync u_rx_busy_sync (.clk(clk), .rst(sys_rst), .din(rx_ff.busy), .dout(rx_busy_s));
  bit_sync u_tx_busy_sync (.clk(clk), .rst(sys_rst), .din(tx_ff.busy), .dout(tx_busy_s));
  bit_sync u_ovr_sync (.clk(clk), .rst(sys_rst), .din(rx_ff.ovr_tgl), .dout(ovr_s));
  bit_sync u_unf_sync (.clk(clk), .rst(sys_rst), .din(tx_ff.unf_tgl), .dout(unf_s));

  // receive side: sync and data both sampled on the falling bit-clock edge
  always_comb begin
    nxt_rx = rx_ff;
    nxt_rx.fs_prev = rx_frame_sync;
    nxt_rx.send = 1'b0;
    case (rx_ff.state)
      LINK_IDLE: begin
        nxt_rx.busy = 1'b0;
      end
      LINK_DELAY: begin
        if (rx_ff.dly_left == `DLY_ONE) begin
          nxt_rx = rx_step(nxt_rx, rx_serial_in, rx_word_busy);
        end else begin
          // framing bit arrives here and is dropped
          nxt_rx.dly_left = rx_ff.dly_left - 2'h1;
        end
      end
      LINK_SHIFT: begin
        nxt_rx = rx_step(nxt_rx, rx_serial_in, rx_word_busy);
      end
      default: begin
        nxt_rx.state = LINK_IDLE;
        nxt_rx.busy = 1'b0;
      end
    endcase
    // a new sync may land on the last bit of the previous frame
    if (rx_frame_sync && !rx_ff.fs_prev && nxt_rx.state == LINK_IDLE) begin
      nxt_rx.cfg = rx_cfg_link;
      nxt_rx.phase = 1'b0;
      nxt_rx.elems_left = phase_count(rx_cfg_link, 1'b0);
      nxt_rx.bits_left = phase_len(rx_cfg_link, 1'b0);
      nxt_rx.shift = `WORD_RESET;
      nxt_rx.dly_left = clamp_delay(rx_cfg_link.delay);
      if (rx_cfg_link.delay == `DLY_ZERO) begin
        nxt_rx = rx_step(nxt_rx, rx_serial_in, rx_word_busy);
      end else begin
        nxt_rx.state = LINK_DELAY;
        nxt_rx.busy = 1'b1;
      end
    end
  end

  always_ff @(negedge rx_bit_clock or posedge sys_rst) begin
    if (sys_rst) begin
      rx_ff <= '0;
    end else begin
      rx_ff <= nxt_rx;
    end
  end

  // transmit side: launched on the rising bit-clock edge
  always_comb begin
    nxt_tx = tx_ff;
    nxt_tx.fs_prev = tx_frame_sync;
    if (tx_word_valid) begin
      nxt_tx.next_word = tx_word_link;
      nxt_tx.fresh = 1'b1;
    end
    case (tx_ff.state)
      LINK_IDLE: begin
        // first bit sits ready at the top so a zero-delay frame can start at once
        nxt_tx.shift = left_align(nxt_tx.next_word, phase_len(tx_cfg_link, 1'b0));
        nxt_tx.busy = 1'b0;
      end
      LINK_DELAY: begin
        nxt_tx.state = LINK_SHIFT;
      end
      LINK_SHIFT: begin
        nxt_tx = tx_step(nxt_tx, tx_cfg_link);
      end
      default: begin
        nxt_tx.state = LINK_IDLE;
        nxt_tx.busy = 1'b0;
      end
    endcase
    if (tx_frame_sync && !tx_ff.fs_prev && nxt_tx.state == LINK_IDLE) begin
      nxt_tx.cfg = tx_cfg_link;
      nxt_tx.phase = 1'b0;
      nxt_tx.elems_left = phase_count(tx_cfg_link, 1'b0);
      nxt_tx.bits_left = phase_len(tx_cfg_link, 1'b0);
      nxt_tx.shift = left_align(nxt_tx.next_word, nxt_tx.bits_left);
      nxt_tx.unf_tgl = nxt_tx.unf_tgl ^ ~nxt_tx.fresh;
      nxt_tx.fresh = 1'b0;
      nxt_tx.busy = 1'b1;
      case (clamp_delay(tx_cfg_link.delay))
        `DLY_ZERO: begin
          // bit one already went out with the sync, move on to bit two
          nxt_tx.state = LINK_SHIFT;
          nxt_tx = tx_step(nxt_tx, tx_cfg_link);
        end
        `DLY_ONE: begin
          nxt_tx.state = LINK_SHIFT;
        end
        default: begin
          nxt_tx.state = LINK_DELAY;
        end
      endcase
    end
  end

  always_ff @(posedge tx_bit_clock or posedge sys_rst) begin
    if (sys_rst) begin
      tx_ff <= '0;
    end else begin
      tx_ff <= nxt_tx;
    end
  end

  assign tx_serial_out = tx_ff.shift[31];
  // zero delay drives straight off the sync pin, ahead of any clocked logic
  assign tx_serial_oe_n = ~((tx_ff.state == LINK_SHIFT) ||
                            (tx_ff.state == LINK_IDLE && tx_frame_sync &&
                             tx_cfg_link.delay == `DLY_ZERO));

  // system side: sticky error flags, a new event beats a clear in the same cycle
  always_comb begin
    nxt_sys = sys_ff;
    nxt_sys.ovr_seen = ovr_s;
    nxt_sys.unf_seen = unf_s;
    if (rx_overrun_clr) begin
      nxt_sys.rx_overrun = 1'b0;
    end
    if (ovr_s != sys_ff.ovr_seen) begin
      nxt_sys.rx_overrun = 1'b1;
    end
    if (tx_underrun_clr) begin
      nxt_sys.tx_underrun = 1'b0;
    end
    if (unf_s != sys_ff.unf_seen) begin
      nxt_sys.tx_underrun = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      sys_ff <= '0;
    end else begin
      sys_ff <= nxt_sys;
    end
  end

  assign tx_ready = ~tx_word_busy;
  assign rx_busy = rx_busy_s;
  assign tx_busy = tx_busy_s;
  assign rx_overrun = sys_ff.rx_overrun;
  assign tx_underrun = sys_ff.tx_underrun;

endmodule
`default_nettype wire

/* src/serial_frame_format_regs.svh */
// constants for the serial frame-format block: delays, length codes, reset values
`ifndef SERIAL_FRAME_FORMAT_REGS_SVH
`define SERIAL_FRAME_FORMAT_REGS_SVH

`define DLY_ZERO 2'h0
`define DLY_ONE 2'h1
`define DLY_TWO 2'h2
`define DLY_RSVD 2'h3

`define PHASE_SINGLE 1'h0
`define PHASE_DUAL 1'h1

`define ELEM_CODE_8 3'h0
`define ELEM_CODE_12 3'h1
`define ELEM_CODE_16 3'h2
`define ELEM_CODE_20 3'h3
`define ELEM_CODE_24 3'h4
`define ELEM_CODE_32 3'h5

// element length minus one, as loaded into the bit counters
`define ELEM_LEN_8 5'h07
`define ELEM_LEN_12 5'h0B
`define ELEM_LEN_16 5'h0F
`define ELEM_LEN_20 5'h13
`define ELEM_LEN_24 5'h17
`define ELEM_LEN_32 5'h1F

`define WORD_RESET 32'h0000_0000
`define SHIFT_TOP 5'h1F

`endif

/* src/serial_frame_format_pkg.sv */
// types shared by the serial frame-format block
package serial_frame_format_pkg;

  typedef struct packed {
    logic dual;
    logic [6:0] p1_count;
    logic [6:0] p2_count;
    logic [2:0] p1_bits;
    logic [2:0] p2_bits;
    logic [1:0] delay;
  } frame_cfg_t;

  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00,
    LINK_DELAY = 2'b01,
    LINK_SHIFT = 2'b10
  } link_state_t;

  typedef struct packed {
    link_state_t state;
    logic busy;
    logic fs_prev;
    logic phase;
    logic [6:0] elems_left;
    logic [4:0] bits_left;
    logic [1:0] dly_left;
    logic [31:0] shift;
    logic [31:0] word;
    logic send;
    logic ovr_tgl;
    frame_cfg_t cfg;
  } rx_link_t;

  typedef struct packed {
    link_state_t state;
    logic busy;
    logic fs_prev;
    logic phase;
    logic [6:0] elems_left;
    logic [4:0] bits_left;
    logic [31:0] shift;
    logic [31:0] next_word;
    logic fresh;
    logic unf_tgl;
    frame_cfg_t cfg;
  } tx_link_t;

  typedef struct packed {
    logic ovr_seen;
    logic unf_seen;
    logic rx_overrun;
    logic tx_underrun;
  } sys_state_t;

endpackage

/* src/bit_sync.sv */
// three-flop level synchroniser; output follows once the last two stages agree
`timescale 1ns/10ps
`default_nettype none
module bit_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic din,
  output logic dout
);
  logic [2:0] stage_ff;
  logic out_ff;

  // stage_ff[0] feeds only stage_ff[1]
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stage_ff <= 3'h0;
      out_ff <= 1'b0;
    end else begin
      stage_ff <= {stage_ff[1:0], din};
      if (stage_ff[1] == stage_ff[2]) begin
        out_ff <= stage_ff[2];
      end
    end
  end

  assign dout = out_ff;
endmodule
`default_nettype wire

/* src/word_xfer.sv */
// toggle-handshake crossing of one held word between two clock domains
`timescale 1ns/10ps
`default_nettype none
module word_xfer #(
  parameter int WIDTH = 32
) (
  input wire logic rst,
  input wire logic src_clk,
  input wire logic src_send,
  input wire logic [WIDTH-1:0] src_data,
  output logic src_busy,
  input wire logic dst_clk,
  output logic [WIDTH-1:0] dst_data,
  output logic dst_valid
);
  logic req_ff;
  logic [WIDTH-1:0] hold_ff;
  logic ack_s;
  logic req_s;
  logic seen_ff;
  logic valid_ff;
  logic [WIDTH-1:0] dst_ff;

  bit_sync u_ack_sync (.clk(src_clk), .rst(rst), .din(seen_ff), .dout(ack_s));
  bit_sync u_req_sync (.clk(dst_clk), .rst(rst), .din(req_ff), .dout(req_s));

  assign src_busy = req_ff ^ ack_s;

  // hold_ff stays put until the far side has acknowledged, so it is safe to sample
  always_ff @(posedge src_clk or posedge rst) begin
    if (rst) begin
      req_ff <= 1'b0;
      hold_ff <= '0;
    end else if (src_send && !src_busy) begin
      req_ff <= ~req_ff;
      hold_ff <= src_data;
    end
  end

  always_ff @(posedge dst_clk or posedge rst) begin
    if (rst) begin
      seen_ff <= 1'b0;
      valid_ff <= 1'b0;
      dst_ff <= '0;
    end else begin
      seen_ff <= req_s;
      valid_ff <= req_s ^ seen_ff;
      if (req_s ^ seen_ff) begin
        dst_ff <= hold_ff;
      end
    end
  end

  assign dst_data = dst_ff;
  assign dst_valid = valid_ff;
endmodule
`default_nettype wire

/* test/serial_frame_format_asserts.sv */
// port checker for the frame-format block, bound to its top module
`timescale 1ns/10ps
`default_nettype none
module serial_frame_format_asserts
  import serial_frame_format_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire frame_cfg_t rx_cfg,
  input wire frame_cfg_t tx_cfg,
  input wire logic tx_bit_clock,
  input wire logic tx_frame_sync,
  input wire logic tx_serial_oe_n,
  input wire logic [31:0] rx_data_holding,
  input wire logic rx_data_valid,
  input wire logic tx_data_write,
  input wire logic tx_ready
);
  property p_valid_pulse;
    @(posedge clk) disable iff (sys_rst) rx_data_valid |=> !rx_data_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
  property p_ready_cycle;
    @(posedge clk) disable iff (sys_rst)
      tx_data_write && tx_ready |=> !tx_ready ##[1:300] tx_ready;
  endproperty
  a_ready_cycle: assert property (p_ready_cycle) else $error("tx_ready cycle");
  property p_rx_width;
    @(posedge clk) disable iff (sys_rst) rx_data_valid && !rx_cfg.dual && rx_cfg.p1_bits < 3'h5
      |-> (rx_data_holding >> (8 + 4 * rx_cfg.p1_bits)) == 32'h0;
  endproperty
  a_rx_width: assert property (p_rx_width) else $error("rx word too wide");
  property p_rx_dual_width;
    @(posedge clk) disable iff (sys_rst) rx_data_valid && rx_cfg.dual && rx_cfg.p1_bits < 3'h2
      && rx_cfg.p2_bits < 3'h2 |-> rx_data_holding[31:12] == 20'h0;
  endproperty
  a_rx_dual_width: assert property (p_rx_dual_width) else $error("dual word wide");
  property p_oe_dly0;
    @(posedge tx_bit_clock) disable iff (sys_rst)
      tx_cfg.delay == 2'h0 && $rose(tx_frame_sync) |-> !tx_serial_oe_n;
  endproperty
  a_oe_dly0: assert property (p_oe_dly0) else $error("zero delay not driven");
  property p_oe_dly1;
    @(posedge tx_bit_clock) disable iff (sys_rst)
      tx_cfg.delay == 2'h1 && $rose(tx_frame_sync) |-> tx_serial_oe_n ##1 !tx_serial_oe_n;
  endproperty
  a_oe_dly1: assert property (p_oe_dly1) else $error("one delay timing");
  property p_oe_dly2;
    @(posedge tx_bit_clock) disable iff (sys_rst) tx_cfg.delay == 2'h2
      && $rose(tx_frame_sync) |-> tx_serial_oe_n ##1 tx_serial_oe_n ##1 !tx_serial_oe_n;
  endproperty
  a_oe_dly2: assert property (p_oe_dly2) else $error("framing bit driven");
  property p_oe_len;
    @(posedge tx_bit_clock) disable iff (sys_rst) tx_cfg.delay == 2'h1 && !tx_cfg.dual
      && tx_cfg.p1_count == 7'h0 && tx_cfg.p1_bits == 3'h0 && $rose(tx_frame_sync)
      |=> !tx_serial_oe_n [*8] ##1 tx_serial_oe_n;
  endproperty
  a_oe_len: assert property (p_oe_len) else $error("frame length wrong");
  c_rx_word: cover property (@(posedge clk) rx_data_valid);
  c_tx_write: cover property (@(posedge clk) tx_data_write && tx_ready);
  c_tx_dual: cover property (@(posedge tx_bit_clock) tx_cfg.dual && $rose(tx_frame_sync));
endmodule
bind serial_frame_format serial_frame_format_asserts chk_u (.clk(clk), .sys_rst(sys_rst),
  .rx_cfg(rx_cfg), .tx_cfg(tx_cfg), .tx_bit_clock(tx_bit_clock),
  .tx_frame_sync(tx_frame_sync), .tx_serial_oe_n(tx_serial_oe_n),
  .rx_data_holding(rx_data_holding), .rx_data_valid(rx_data_valid),
  .tx_data_write(tx_data_write), .tx_ready(tx_ready));
`default_nettype wire

/* test/link_partner.sv */
// far-side framing device: bit clock, frame syncs, serial data
`timescale 1ns/10ps
`default_nettype none
module link_partner (
  output logic bit_clk,
  output logic rx_sync,
  output logic rx_data,
  output logic tx_sync,
  input wire logic tx_data,
  input wire logic tx_oe_n
);
  logic idle;
  wire logic line_level;
  // board pull-up shows whenever the block floats the line
  assign line_level = tx_oe_n ? 1'b1 : tx_data;
  // codec clock runs on; the block's config crossing needs it
  initial begin
    bit_clk = 1'b0;
    rx_sync = 1'b0;
    rx_data = 1'b0;
    tx_sync = 1'b0;
    idle = 1'b1;
    #3;
    forever #15 bit_clk = ~bit_clk;
  end
  // released line: keep it moving so stale bits cannot pass
  always @(posedge bit_clk) begin
    if (idle) begin
      rx_data <= ~rx_data;
    end
  end
  task automatic send(input int d, input logic bits[$]);
    idle = 1'b0;
    for (int i = 0; i < d + bits.size(); i++) begin
      @(posedge bit_clk);
      rx_sync <= (i == 0);
      rx_data <= (i < d) ? ~bits[0] : bits[i - d];
    end
    @(posedge bit_clk);
    rx_sync <= 1'b0;
    idle = 1'b1;
  endtask
  task automatic take(input int d, input int n, output logic [127:0] got,
      output logic [127:0] oe);
    @(posedge bit_clk);
    tx_sync <= 1'b1;
    for (int i = 0; i < n + d; i++) begin
      @(negedge bit_clk);
      got[i] = line_level;
      oe[i] = tx_oe_n;
      @(posedge bit_clk);
      tx_sync <= 1'b0;
    end
  endtask
endmodule
`default_nettype wire

/* test/serial_frame_format_tb.sv */
// self-checking bench for the frame-format block
`timescale 1ns/10ps
`default_nettype none
module serial_frame_format_tb
  import serial_frame_format_pkg::*;
;
  logic clk, sys_rst, bclk, rx_fs, rx_in, tx_fs, tx_out, tx_oe_n, rx_valid, tx_wr, tx_ready;
  logic [31:0] rx_word, tx_word;
  logic rx_bsy, tx_bsy, rx_ovr, tx_unf, tx_unf_clr;
  frame_cfg_t cfg;
  logic [31:0] rxq[$];
  int err_total = 0;
  int comparisons = 0;
  serial_frame_format dut_u (.clk(clk), .sys_rst(sys_rst), .rx_cfg(cfg), .tx_cfg(cfg),
    .rx_bit_clock(bclk), .rx_frame_sync(rx_fs), .rx_serial_in(rx_in), .tx_bit_clock(bclk),
    .tx_frame_sync(tx_fs), .tx_serial_out(tx_out), .tx_serial_oe_n(tx_oe_n),
    .rx_data_holding(rx_word), .rx_data_valid(rx_valid), .tx_data_holding(tx_word),
    .tx_data_write(tx_wr), .tx_ready(tx_ready), .rx_busy(rx_bsy), .tx_busy(tx_bsy),
    .rx_overrun(rx_ovr), .rx_overrun_clr(1'b0), .tx_underrun(tx_unf),
    .tx_underrun_clr(tx_unf_clr));
  link_partner far_u (.bit_clk(bclk), .rx_sync(rx_fs), .rx_data(rx_in), .tx_sync(tx_fs),
    .tx_data(tx_out), .tx_oe_n(tx_oe_n));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (rx_valid === 1'b1) begin
      rxq.push_back(rx_word);
    end
  end
  function automatic int wid(input logic [2:0] c);
    return (c == 3'h5) ? 32 : 8 + 4 * c;
  endfunction
  function automatic logic [31:0] low(input logic [31:0] v, input int w);
    return (w == 32) ? v : v & ((32'h1 << w) - 32'h1);
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic setup(input logic dual, input logic [6:0] n1, input logic [6:0] n2,
      input logic [2:0] b1, input logic [2:0] b2, input logic [1:0] d);
    @(posedge clk);
    cfg <= '{dual, n1, n2, b1, b2, d};
    repeat (30) @(posedge bclk);
  endtask
  task automatic await_ready;
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (tx_ready !== 1'b1 && k < 500);
    if (k >= 500) begin
      err_total++;
      $display("[FAIL] %0t tx_ready stuck", $time);
    end
  endtask
  task automatic put(input logic [31:0] w);
    await_ready();
    tx_word <= w;
    tx_wr <= 1'b1;
    @(posedge clk);
    tx_wr <= 1'b0;
    await_ready();
  endtask
  task automatic rx_run(input logic [31:0] v[$], input int w[$], input int d);
    logic bits[$];
    int k;
    foreach (v[i]) begin
      for (int j = w[i] - 1; j >= 0; j--) begin
        bits.push_back(v[i][j]);
      end
    end
    far_u.send(d, bits);
    k = 0;
    while (rxq.size() < v.size() && k < 2000) begin
      @(posedge clk);
      k++;
    end
    repeat (100) @(posedge clk);
    chk(rxq.size(), v.size());
    foreach (v[i]) begin
      if (rxq.size() > 0) begin
        chk(rxq.pop_front(), v[i]);
      end
    end
    rxq.delete();
  endtask
  task automatic tx_run(input int d, input int n1, input int n2, input logic [31:0] w1,
      input logic [31:0] w2);
    logic [127:0] got, oe;
    logic [31:0] gw, bad;
    put(w1);
    repeat (3) @(posedge bclk);
    fork
      far_u.take(d, n1 + n2, got, oe);
      if (n2 > 0) begin
        repeat (3) @(posedge bclk);
        put(w2);
      end
    join
    gw = 32'h0;
    bad = 32'h0;
    for (int i = 0; i < d + n1 + n2; i++) begin
      if (i >= d) begin
        gw = {gw[30:0], got[i]};
      end
      bad = bad + ((oe[i] !== (i < d)) ? 32'h1 : 32'h0);
    end
    chk(gw, (low(w1, n1) << n2) | low(w2, n2));
    chk(bad, 32'h0);
  endtask
  task automatic t_rx_codes;
    for (int c = 0; c < 6; c++) begin
      setup(1'b0, 7'h0, 7'h55, c[2:0], 3'h7, 2'(c % 3));
      rx_run('{32'hB5E3_96C7 >> (32 - wid(c[2:0]))}, '{wid(c[2:0])}, c % 3);
    end
  endtask
  task automatic t_rx_dual;
    setup(1'b1, 7'h1, 7'h2, 3'h1, 3'h0, 2'h1);
    rx_run('{32'hB5E, 32'h396, 32'hC7, 32'h5A, 32'h81}, '{12, 12, 8, 8, 8}, 1);
  endtask
  task automatic t_rx_long;
    logic [31:0] v[$];
    int w[$];
    for (int i = 0; i < 128; i++) begin
      v.push_back(32'(i) ^ 32'hA5);
      w.push_back(8);
    end
    setup(1'b0, 7'h7F, 7'h0, 3'h0, 3'h0, 2'h0);
    rx_run(v, w, 0);
  endtask
  task automatic t_tx_codes;
    for (int c = 0; c < 6; c++) begin
      setup(1'b0, 7'h0, 7'h33, c[2:0], 3'h6, 2'((c + 1) % 3));
      tx_run((c + 1) % 3, wid(c[2:0]), 0, 32'h7A3C_E159 ^ 32'(c), 32'h0);
    end
  endtask
  task automatic t_tx_dual;
    setup(1'b1, 7'h0, 7'h0, 3'h1, 3'h0, 2'h1);
    tx_run(1, 12, 8, 32'h0000_0A5C, 32'h0000_0093);
  endtask
  // both links in one frame; transmit gets no new word, so the old one repeats
  task automatic t_flags;
    logic [127:0] got, oe;
    fork
      far_u.take(1, 20, got, oe);
      rx_run('{32'hABC, 32'h5D}, '{12, 8}, 1);
      begin
        repeat (6) @(posedge bclk);
        @(posedge clk);
        chk(tx_bsy, 1'b1);
        chk(rx_bsy, 1'b1);
      end
    join
    chk(tx_bsy, 1'b0);
    chk(rx_bsy, 1'b0);
    chk(rx_ovr, 1'b0);
    chk(tx_unf, 1'b1);
    tx_unf_clr <= 1'b1;
    @(posedge clk);
    tx_unf_clr <= 1'b0;
    @(posedge clk);
    chk(tx_unf, 1'b0);
  endtask
  task automatic wrap_up;
    if (err_total == 0 && comparisons > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    sys_rst = 1'b1;
    cfg = '0;
    tx_word = 32'h0;
    tx_wr = 1'b0;
    tx_unf_clr = 1'b0;
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (30) @(posedge bclk);
    t_rx_codes();
    t_rx_dual();
    t_rx_long();
    t_tx_codes();
    t_tx_dual();
    t_flags();
    wrap_up();
  end
  initial begin
    #500000;
    err_total++;
    $display("[FAIL] %0t run hung", $time);
    wrap_up();
  end
endmodule
`default_nettype wire
